// ### afm_consts.svh
// constants for the actuator fault manager
`ifndef AFM_CONSTS_SVH
`define AFM_CONSTS_SVH
`define AFM_NF 14
`define AFM_NI 10
`define AFM_TW 26
`define AFM_F_FREQ 0
`define AFM_F_SENSOR 1
`define AFM_F_INTERNAL 2
`define AFM_F_DUTY_HI 3
`define AFM_F_DUTY_LO 4
`define AFM_F_VOLT_HI 5
`define AFM_F_VOLT_LO 6
`define AFM_F_TEMP_HI 7
`define AFM_F_TEMP_LO 8
`define AFM_F_POS_ERR 9
`define AFM_F_PWR_UP 10
`define AFM_F_LOW_PWR 11
`define AFM_F_WDOG 12
`define AFM_F_SPRING 13
`define AFM_HARD_SD 14'h0007
`define AFM_HARD_LATCH 14'h0006
`define AFM_I_EXT_ADC 4
`define AFM_CLK_HZ 100000000
`define AFM_FREQ_MIN_HZ 250
`define AFM_FREQ_MAX_HZ 20000
`define AFM_EXT_ADC_MS 5
`define AFM_INT_ADC_MS 50
`define AFM_SPR_START_MS 200
`define AFM_CYC_PER_MS (`AFM_CLK_HZ / 1000)
`define AFM_TEMP_HI_C 10'sh08C
`define AFM_TEMP_LO_C (-10'sh02D)
`define AFM_PM_FULL 10'h3E8
`endif

// ### afm_fault_manager.sv
// fault supervision core: detection, latching, actions and log
`include "afm_consts.svh"
module afm_fault_manager import afm_pkg::*; #(
    parameter int FREQ_SLOW_CYC = `AFM_CLK_HZ / `AFM_FREQ_MIN_HZ,  // 250 Hz period
    parameter int FREQ_FAST_CYC = `AFM_CLK_HZ / `AFM_FREQ_MAX_HZ,  // 20 kHz period
    parameter int EXT_ADC_CYC = `AFM_CYC_PER_MS * `AFM_EXT_ADC_MS,  // 5 ms
    parameter int INT_ADC_CYC = `AFM_CYC_PER_MS * `AFM_INT_ADC_MS,  // 50 ms
    parameter int SPR_START_CYC = `AFM_CYC_PER_MS * `AFM_SPR_START_MS  // 200 ms
) (
    input wire logic CORE_CLK,  // core clock, 100 MHz
    input wire logic NRST,  // sync reset, active low
    input wire logic DEMAND_IN,  // demand pulse train
    input wire logic [9:0] DUTY_HI_PM,  // duty high threshold
    input wire logic [9:0] DUTY_LO_PM,  // duty low threshold
    input wire logic [15:0] SUPPLY_MV,  // measured supply
    input wire logic [15:0] VOLT_HI_MV,  // supply high threshold
    input wire logic [15:0] VOLT_LO_MV,  // supply low threshold
    input wire logic signed [9:0] TEMP_C,  // electronics temperature
    input wire logic SENSOR_BAD,  // position sensor failed
    input wire logic POS_MISMATCH,  // feedback off demand
    input wire afm_tcnt_t POS_ERR_DELAY,  // tracking allowance, cycles
    input wire logic LOW_VOLT_RST,  // last reset from low voltage
    input wire logic WDOG_RST,  // last reset from watchdog
    input wire logic EE_READ_FAIL,  // memory read failure
    input wire logic EE_WRITE_FAIL,  // memory write failure
    input wire logic PARAM_VER_MIXED,  // stored versions mixed
    input wire logic PARAM_CRC_VALID,  // computed check code ready
    input wire logic [15:0] PARAM_CRC_STORED,  // stored check code
    input wire logic [15:0] PARAM_CRC_CALC,  // computed check code
    input wire logic EXT_ADC_DONE,  // external converter round done
    input wire logic INT_ADC_IRQ,  // on-chip converter interrupt
    input wire logic INT_ADC_UPDATE,  // on-chip converter update
    input wire logic [3:0] RAIL_BAD,  // 5 V, -5 V ref, -15 V, +15 V
    input wire logic SPRING_EN,  // spring check configured
    input wire logic POS_CTRL_READY,  // position control active
    input wire logic AT_START,  // output at start position
    input wire logic AT_FINISH,  // output at finish position
    input wire logic DEMAND_VALID,  // valid demand present
    input wire afm_tcnt_t SPRING_TIMEOUT,  // finish timeout, cycles
    input wire afm_fvec_t FAULT_USED,  // per-fault used
    input wire afm_fvec_t FAULT_SHUTDOWN,  // per-fault shutdown
    input wire afm_fvec_t FAULT_DOUT_EN,  // per-fault discrete output
    input wire logic LATCH_ALL,  // global latching
    input wire logic RESET_FAULTS,  // reset active faults, pulse
    input wire logic CLEAR_LOG,  // clear logged faults, pulse
    input wire logic LOG_LOAD,  // restore log from storage, pulse
    input wire afm_fvec_t LOG_LOAD_DATA,  // log image to restore
    output afm_fvec_t ACTIVE,  // active faults
    output afm_fvec_t LOGGED,  // logged faults
    output logic [`AFM_NI-1:0] INTERNAL_CAUSE,  // latched internal causes
    output logic SHUTDOWN,  // force predetermined position
    output logic ALARM,  // annunciate only
    output logic FAIL_DRIVE,  // current control to fail direction
    output logic DISCRETE_OUT,  // discrete output state
    output logic SPRING_SEEK,  // drive to spring start
    output logic SPRING_LIMP,  // zero drive current
    output logic SPRING_PASSED,  // spring check passed
    output logic SPRING_SKIPPED  // spring check not performed
);

    ////////////////////////////////////////////////////////////////////////////////
    // detectors

    logic freq_bad;  // demand frequency out of window
    logic duty_hi;  // duty over high threshold
    logic duty_lo;  // duty under low threshold
    logic ext_adc_exp;  // external converter silent
    logic int_adc_exp;  // on-chip converter silent
    logic pos_err_exp;  // tracking error outlasted allowance
    logic pwr_up;  // first cycle after power-up reset
    afm_spr_t spr_state;  // spring check state
    afm_spr_t next_spr_state;
    afm_tcnt_t spr_cnt;  // spring phase timer

    afm_pwm_mon #(
        .SLOW_CYC(FREQ_SLOW_CYC),
        .FAST_CYC(FREQ_FAST_CYC)
    ) u_pwm (
        .clk(CORE_CLK),
        .nrst(NRST),
        .demand(DEMAND_IN),
        .hi_pm(DUTY_HI_PM),
        .lo_pm(DUTY_LO_PM),
        .freq_bad(freq_bad),
        .duty_hi(duty_hi),
        .duty_lo(duty_lo)
    );

    // external converter must finish a full round every 5 ms
    afm_timeout u_ext_adc (
        .clk(CORE_CLK),
        .nrst(NRST),
        .act(EXT_ADC_DONE),
        .limit(EXT_ADC_CYC[`AFM_TW-1:0]),
        .expired(ext_adc_exp)
    );

    // either an interrupt or an update keeps the on-chip converter alive
    afm_timeout u_int_adc (
        .clk(CORE_CLK),
        .nrst(NRST),
        .act(INT_ADC_IRQ || INT_ADC_UPDATE),
        .limit(INT_ADC_CYC[`AFM_TW-1:0]),
        .expired(int_adc_exp)
    );

    // tracking must fail for the whole allowance, so transients pass
    afm_timeout u_pos_err (
        .clk(CORE_CLK),
        .nrst(NRST),
        .act(!POS_MISMATCH),
        .limit(POS_ERR_DELAY),
        .expired(pos_err_exp)
    );

    // internal causes, one bit each
    wire crc_bad = PARAM_CRC_VALID && (PARAM_CRC_STORED != PARAM_CRC_CALC);
    wire [`AFM_NI-1:0] int_raw = {
        RAIL_BAD,
        int_adc_exp,
        ext_adc_exp,
        crc_bad,
        PARAM_VER_MIXED,
        EE_WRITE_FAIL,
        EE_READ_FAIL
    };

    // supply and temperature windows
    wire volt_hi = SUPPLY_MV > VOLT_HI_MV;
    wire volt_lo = SUPPLY_MV < VOLT_LO_MV;
    wire temp_hi = TEMP_C > `AFM_TEMP_HI_C;
    wire temp_lo = TEMP_C < `AFM_TEMP_LO_C;

    // raw condition vector in fault order
    wire afm_fvec_t cond = {
        spr_state == SPR_FAILED,
        WDOG_RST,
        LOW_VOLT_RST,
        pwr_up,
        pos_err_exp,
        temp_lo,
        temp_hi,
        volt_lo,
        volt_hi,
        duty_lo,
        duty_hi,
        |int_raw,
        SENSOR_BAD,
        freq_bad
    };

    ////////////////////////////////////////////////////////////////////////////////
    // configuration and latching

    // shutdown-only faults cannot be ignored or turned into alarms
    wire afm_fvec_t used_eff = FAULT_USED | `AFM_HARD_SD;
    wire afm_fvec_t sd_eff = FAULT_SHUTDOWN | `AFM_HARD_SD;
    wire afm_fvec_t latch_eff = {`AFM_NF{LATCH_ALL}} | `AFM_HARD_LATCH;
    wire afm_fvec_t cond_u = cond & used_eff;
    afm_fvec_t next_active;
    afm_fvec_t next_logged;

    // per fault: detection sets, latch holds, reset only frees what is gone;
    // a detection in the reset cycle wins, so a live fault never drops
    genvar gi;
    generate
        for (gi = 0; gi < `AFM_NF; gi++) begin : g_fault
            wire held = ACTIVE[gi] && latch_eff[gi] && used_eff[gi] && !RESET_FAULTS;
            assign next_active[gi] = cond_u[gi] || held;
            wire fell = ACTIVE[gi] && !next_active[gi];
            wire kept = LOG_LOAD ? LOG_LOAD_DATA[gi] : (LOGGED[gi] && !CLEAR_LOG);
            assign next_logged[gi] = kept || fell;
        end
    endgenerate

    // internal causes latch on their own and stay until reset
    wire [`AFM_NI-1:0] next_cause = int_raw | (INTERNAL_CAUSE & {`AFM_NI{!RESET_FAULTS}});

    // fault and log state
    always_ff @(posedge CORE_CLK) begin
        if (!NRST) begin
            ACTIVE <= '0;
            LOGGED <= '0;
            INTERNAL_CAUSE <= '0;
            pwr_up <= 1'b1;
        end else begin
            ACTIVE <= next_active;
            LOGGED <= next_logged;
            INTERNAL_CAUSE <= next_cause;
            pwr_up <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // actions

    assign SHUTDOWN = |(ACTIVE & sd_eff);
    assign ALARM = |(ACTIVE & ~sd_eff);
    assign FAIL_DRIVE = ACTIVE[`AFM_F_SENSOR] || ACTIVE[`AFM_F_INTERNAL];
    assign DISCRETE_OUT = |(ACTIVE & FAULT_DOUT_EN);

    ////////////////////////////////////////////////////////////////////////////////
    // return spring check at power-up

    wire spr_abort = DEMAND_VALID || SHUTDOWN;  // a live demand or shutdown wins
    wire start_late = spr_cnt >= SPR_START_CYC[`AFM_TW-1:0];
    wire finish_late = spr_cnt >= SPRING_TIMEOUT;

    // sequence: seek start, go limp, expect the spring to reach finish
    always_comb begin
        next_spr_state = spr_state;
        case (spr_state)
            SPR_IDLE: begin
                if (POS_CTRL_READY) begin
                    next_spr_state = SPRING_EN ? SPR_TO_START : SPR_SKIPPED;
                end
            end
            SPR_TO_START: begin
                if (spr_abort) begin
                    next_spr_state = SPR_SKIPPED;
                end else if (AT_START) begin
                    next_spr_state = SPR_LIMP;
                end else if (start_late) begin
                    next_spr_state = SPR_FAILED;
                end
            end
            SPR_LIMP: begin
                if (spr_abort) begin
                    next_spr_state = SPR_SKIPPED;
                end else if (AT_FINISH) begin
                    next_spr_state = SPR_PASSED;
                end else if (finish_late) begin
                    next_spr_state = SPR_FAILED;
                end
            end
            default: begin
                next_spr_state = spr_state;  // end states hold until power cycle
            end
        endcase
    end

    // timer restarts on every state change
    always_ff @(posedge CORE_CLK) begin
        if (!NRST) begin
            spr_state <= SPR_IDLE;
            spr_cnt <= '0;
        end else begin
            spr_state <= next_spr_state;
            spr_cnt <= (next_spr_state != spr_state) ? '0 : spr_cnt + 1'b1;
        end
    end

    assign SPRING_SEEK = spr_state == SPR_TO_START;
    assign SPRING_LIMP = spr_state == SPR_LIMP;
    assign SPRING_PASSED = spr_state == SPR_PASSED;
    assign SPRING_SKIPPED = spr_state == SPR_SKIPPED;

    ////////////////////////////////////////////////////////////////////////////////
    // checks

    property p_detect;
        @(posedge CORE_CLK) disable iff (!NRST) cond_u[`AFM_F_TEMP_HI] |=> ACTIVE[`AFM_F_TEMP_HI];
    endproperty
    a_detect: assert property (p_detect) else $error("detected fault not active");

    property p_latch;
        @(posedge CORE_CLK) disable iff (!NRST)
            (LATCH_ALL && FAULT_USED[`AFM_F_POS_ERR] && ACTIVE[`AFM_F_POS_ERR]
            && !RESET_FAULTS) |=> ACTIVE[`AFM_F_POS_ERR];
    endproperty
    a_latch: assert property (p_latch) else $error("latched fault dropped");

    property p_nolatch;
        @(posedge CORE_CLK) disable iff (!NRST)
            (!LATCH_ALL && !cond_u[`AFM_F_VOLT_HI]) |=> !ACTIVE[`AFM_F_VOLT_HI];
    endproperty
    a_nolatch: assert property (p_nolatch) else $error("non-latching fault held");

    property p_hard_sd;
        @(posedge CORE_CLK) disable iff (!NRST) ACTIVE[`AFM_F_FREQ] |-> SHUTDOWN;
    endproperty
    a_hard_sd: assert property (p_hard_sd) else $error("hard shutdown missing");

    property p_dout;
        @(posedge CORE_CLK) disable iff (!NRST)
            (ACTIVE[`AFM_F_VOLT_LO] && FAULT_DOUT_EN[`AFM_F_VOLT_LO]) |-> DISCRETE_OUT;
    endproperty
    a_dout: assert property (p_dout) else $error("discrete output not set");

    property p_log;
        @(posedge CORE_CLK) disable iff (!NRST)
            (ACTIVE[`AFM_F_TEMP_LO] && !next_active[`AFM_F_TEMP_LO]) |=> LOGGED[`AFM_F_TEMP_LO];
    endproperty
    a_log: assert property (p_log) else $error("cleared fault not logged");

    property p_sensor;
        @(posedge CORE_CLK) disable iff (!NRST)
            (ACTIVE[`AFM_F_SENSOR] && !RESET_FAULTS) |=> (ACTIVE[`AFM_F_SENSOR] && FAIL_DRIVE);
    endproperty
    a_sensor: assert property (p_sensor) else $error("sensor fault not latched");

    property p_cause;
        @(posedge CORE_CLK) disable iff (!NRST)
            $rose(INTERNAL_CAUSE[`AFM_I_EXT_ADC]) |-> (ACTIVE[`AFM_F_INTERNAL] && FAIL_DRIVE);
    endproperty
    a_cause: assert property (p_cause) else $error("cause without internal fault");

    property p_alarm;
        @(posedge CORE_CLK) disable iff (!NRST)
            (ACTIVE == 14'h0010 && !FAULT_SHUTDOWN[`AFM_F_DUTY_LO]) |-> (ALARM && !SHUTDOWN);
    endproperty
    a_alarm: assert property (p_alarm) else $error("alarm took action");

    property p_reset_live;
        @(posedge CORE_CLK) disable iff (!NRST)
            (RESET_FAULTS && cond_u[`AFM_F_POS_ERR]) |=> ACTIVE[`AFM_F_POS_ERR];
    endproperty
    a_reset_live: assert property (p_reset_live) else $error("live fault reset");

    property p_spr_start;
        @(posedge CORE_CLK) disable iff (!NRST)
            (spr_state == SPR_TO_START && start_late && !AT_START && !spr_abort)
            |=> spr_state == SPR_FAILED ##1 ACTIVE[`AFM_F_SPRING] == FAULT_USED[`AFM_F_SPRING];
    endproperty
    a_spr_start: assert property (p_spr_start) else $error("spring start timeout missed");

endmodule : afm_fault_manager

// ### afm_fault_manager_tb.sv
// self-checking bench for the actuator fault manager
module afm_fault_manager_tb import afm_pkg::*; ;
    timeunit 1ns;
    timeprecision 1ps;
    ////////////////////////////////////////////////////////////////////////////////
    logic clk, nrst, demand, sensor, mism, lvr, wdr, extd, irq, upd;  // stimulus bits
    logic spr_en, pcr, at_s, at_f, dval, latch, go;  // spring, config, tool strobe
    logic [1:0] cmd;  // tool command code
    logic [9:0] dhi, dlo, raw, cause;  // duty limits, raw and latched internal causes
    logic signed [9:0] temp;  // electronics temperature
    logic [15:0] sup;  // supply reading
    logic [15:0] vhi, vlo, crcs, crcc;  // supply limits, check codes
    afm_tcnt_t pdly, sto;  // position and spring allowances
    afm_fvec_t used, sdn, dout, act, logd, image, ld_data;  // fault vectors
    logic rst_f, clr_l, ld_l, sd, al, fd, dq, seek, limp, pass, skip;  // observed outputs
    int mismatches = 0;  // failed comparisons
    int num_checks = 0;  // comparisons made
    ////////////////////////////////////////////////////////////////////////////////
    // short counts keep the run brief; expectations below use these values
    afm_fault_manager #(.FREQ_SLOW_CYC(400), .FREQ_FAST_CYC(20), .EXT_ADC_CYC(50),
            .INT_ADC_CYC(100), .SPR_START_CYC(60)) u_afm_fault_manager (
        .CORE_CLK(clk), .NRST(nrst), .DEMAND_IN(demand), .DUTY_HI_PM(dhi), .DUTY_LO_PM(dlo),
        .SUPPLY_MV(sup), .VOLT_HI_MV(vhi), .VOLT_LO_MV(vlo), .TEMP_C(temp),
        .SENSOR_BAD(sensor), .POS_MISMATCH(mism), .POS_ERR_DELAY(pdly),
        .LOW_VOLT_RST(lvr), .WDOG_RST(wdr), .EE_READ_FAIL(raw[0]), .EE_WRITE_FAIL(raw[1]),
        .PARAM_VER_MIXED(raw[2]), .PARAM_CRC_VALID(raw[3]), .PARAM_CRC_STORED(crcs),
        .PARAM_CRC_CALC(crcc), .EXT_ADC_DONE(extd), .INT_ADC_IRQ(irq),
        .INT_ADC_UPDATE(upd), .RAIL_BAD(raw[9:6]), .SPRING_EN(spr_en), .POS_CTRL_READY(pcr),
        .AT_START(at_s), .AT_FINISH(at_f), .DEMAND_VALID(dval), .SPRING_TIMEOUT(sto),
        .FAULT_USED(used), .FAULT_SHUTDOWN(sdn), .FAULT_DOUT_EN(dout), .LATCH_ALL(latch),
        .RESET_FAULTS(rst_f), .CLEAR_LOG(clr_l), .LOG_LOAD(ld_l), .LOG_LOAD_DATA(ld_data),
        .ACTIVE(act), .LOGGED(logd), .INTERNAL_CAUSE(cause), .SHUTDOWN(sd), .ALARM(al),
        .FAIL_DRIVE(fd), .DISCRETE_OUT(dq), .SPRING_SEEK(seek), .SPRING_LIMP(limp),
        .SPRING_PASSED(pass), .SPRING_SKIPPED(skip));
    afm_svc_tool u_afm_svc_tool (.go(go), .cmd(cmd), .image(image), .reset_faults(rst_f),
        .clear_log(clr_l), .log_load(ld_l), .log_data(ld_data));
    ////////////////////////////////////////////////////////////////////////////////
    // 100 MHz core clock
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // every drive happens at a falling edge, away from the sampling edge
    task automatic step(input int n);
        repeat (n) @(negedge clk);
    endtask : step
    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
        num_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED at %0t: %s", $time, what);
        end
    endtask : chk
    // one service tool command, then a quiet cycle so go never toggles twice at once
    task automatic tool(input logic [1:0] c);
        cmd = c;
        go = 1'b1;
        step(1);
        go = 1'b0;
        step(1);
    endtask : tool
    // n demand periods of per cycles with hi cycles high
    task automatic pwm(input int per, input int hi, input int n);
        repeat (n) begin
            demand = 1'b1;
            step(hi);
            demand = 1'b0;
            step(per - hi);
        end
    endtask : pwm
    task automatic do_reset();
        nrst = 1'b0;
        step(8);
        nrst = 1'b1;
        step(3);
    endtask : do_reset
    task automatic finish_test();
        if (mismatches == 0 && num_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : finish_test
    ////////////////////////////////////////////////////////////////////////////////
    // watchdog: whole run needs about 2200 cycles
    initial begin
        repeat (20000) @(negedge clk);
        mismatches++;
        finish_test();
    end
    // main sequence
    initial begin
        {sensor, mism, lvr, wdr, spr_en, pcr, at_s, at_f, dval, latch, go, demand} = '0;
        {extd, irq, upd, cmd, raw, image} = {3'h7, 2'h0, 10'h000, 14'h0000};
        {dhi, dlo, temp, sup} = {10'h384, 10'h064, 10'h019, 16'h5DC0};
        {used, sdn, dout} = {14'h3FE7, 14'h0027, 14'h0020};
        {vhi, vlo, crcs, crcc} = {16'h80E8, 16'h2328, 16'h5A5A, 16'h5A5B};
        {pdly, sto} = {26'h0000014, 26'h000001E};
        do_reset();
        chk({act[10], logd[10]}, 2'h1, "power-up indication");
        // supply: threshold is exclusive, supply high drives discrete output, self clears
        sup = 16'h80E8;
        step(2);
        chk(act[5], 1'b0, "supply at high threshold");
        sup = 16'h84D0;
        step(2);
        chk({act[5], sd, al, dq}, 4'hD, "supply high shutdown");
        sup = 16'h5DC0;
        step(2);
        chk({act[5], logd[5], sd}, 3'h2, "supply high self clear");
        sup = 16'h1F40;
        step(2);
        chk({act[6], al, sd, dq}, 4'hC, "supply low alarm");
        used[6] = 1'b0;
        step(2);
        chk(act[6], 1'b0, "ignored fault");
        {used[6], sup} = {1'b1, 16'h5DC0};
        // global latching with temperature
        {latch, temp} = {1'b1, 10'h08C};
        step(2);
        chk(act[7], 1'b0, "temperature at limit");
        temp = 10'h08D;
        step(2);
        tool(2'h1);
        chk(act[7], 1'b1, "reset while present");
        temp = 10'h019;
        step(2);
        chk(act[7], 1'b1, "latched after clear");
        tool(2'h1);
        chk({act[7], logd[7], logd[5]}, 3'h3, "reset command clears");
        {latch, temp} = {1'b0, 10'h3D3};
        step(2);
        chk(act[8], 1'b0, "temperature at low limit");
        temp = 10'h3D2;
        step(2);
        chk(act[8], 1'b1, "temperature low");
        temp = 10'h019;
        // sensor failure latches regardless of global setting
        sensor = 1'b1;
        step(2);
        chk({act[1], fd, sd}, 3'h7, "sensor fail drive");
        sensor = 1'b0;
        step(2);
        chk(act[1], 1'b1, "sensor latched");
        tool(2'h1);
        chk(act[1], 1'b0, "sensor reset");
        // each internal cause on its own, skipping the two converter timeouts
        for (int i = 0; i < 10; i++) begin
            if (i == 4 || i == 5) continue;
            raw = 10'h001 << i;
            step(2);
            chk(cause, 10'h001 << i, "internal cause");
            chk({act[2], fd, sd}, 3'h7, "internal fail drive");
            raw = 10'h000;
            step(2);
            tool(2'h1);
            chk({act[2], cause}, 11'h000, "internal reset");
        end
        // matching check codes with a valid compare raise nothing
        {raw[3], crcc} = {1'b1, 16'h5A5A};
        step(2);
        chk({act[2], cause}, 11'h000, "check codes agree");
        raw[3] = 1'b0;
        // converter silence just under and just over the limit
        for (int k = 0; k < 2; k++) begin
            if (k == 0) extd = 1'b0;
            else {irq, upd} = 2'h0;
            step(k == 0 ? 45 : 95);
            chk(cause[4 + k], 1'b0, "converter early");
            step(10);
            chk(cause[4 + k], 1'b1, "converter silent");
            {extd, irq, upd} = 3'h7;
            step(2);  // let the expiry fall before the reset command
            tool(2'h1);
            chk({act[2], cause}, 11'h000, "converter reset");
        end
        // tracking error must outlast the response allowance
        mism = 1'b1;
        step(10);
        mism = 1'b0;
        step(3);
        chk(act[9], 1'b0, "short mismatch");
        mism = 1'b1;
        step(30);
        chk(act[9], 1'b1, "position error");
        tool(2'h1);
        chk(act[9], 1'b1, "mismatch survives reset");
        {mism, lvr, wdr} = 3'h3;
        step(2);
        chk(act[12:9], 4'hC, "reset causes");
        {lvr, wdr} = 2'h0;
        // demand duty and frequency
        used[4:3] = 2'h3;
        pwm(100, 50, 4);
        chk({act[0], act[4:3]}, 3'h0, "demand normal");
        pwm(100, 95, 3);
        chk(act[3], 1'b1, "duty high");
        dhi = 10'h3C0;
        pwm(100, 95, 3);
        chk(act[3], 1'b0, "duty under raised limit");
        pwm(100, 5, 3);
        chk(act[4], 1'b1, "duty low");
        pwm(10, 5, 4);
        chk({act[0], sd}, 2'h3, "frequency too high");
        pwm(100, 50, 4);
        chk(act[0], 1'b0, "frequency back");
        used[4:3] = 2'h0;
        // log clear and restore
        tool(2'h2);
        chk(logd, 14'h0000, "log cleared");
        image = 14'h2A55;
        tool(2'h3);
        chk(logd, 14'h2A55, "log restored");
        // spring check: fail on finish timeout, then pass, then skipped on demand
        {spr_en, pcr} = 2'h3;
        step(2);
        chk(seek, 1'b1, "spring seek");
        at_s = 1'b1;
        step(2);
        chk(limp, 1'b1, "spring limp");
        step(20);
        chk(act[13], 1'b0, "spring within timeout");
        step(20);
        chk(act[13], 1'b1, "spring timeout");
        at_f = 1'b1;
        do_reset();
        step(3);
        chk({pass, act[13]}, 2'h2, "spring passed");
        dval = 1'b1;
        do_reset();
        step(3);
        chk(skip, 1'b1, "spring skipped");
        {dval, at_s} = 2'h0;
        do_reset();
        step(62);
        chk(act[13], 1'b1, "spring start timeout");
        finish_test();
    end
endmodule : afm_fault_manager_tb

// ### afm_pkg.sv
// types shared by the actuator fault manager
`include "afm_consts.svh"
package afm_pkg;
    typedef logic [`AFM_NF-1:0] afm_fvec_t;  // one bit per fault
    typedef logic [`AFM_TW-1:0] afm_tcnt_t;  // timer count
    // return spring check progress
    typedef enum logic [2:0] {
        SPR_IDLE, SPR_TO_START, SPR_LIMP, SPR_PASSED, SPR_FAILED, SPR_SKIPPED
    } afm_spr_t;
endpackage : afm_pkg

// ### afm_pwm_mon.sv
// demand pulse train monitor: frequency window and duty limits
`include "afm_consts.svh"
module afm_pwm_mon import afm_pkg::*; #(
    parameter int SLOW_CYC = 400000,  // period of lowest frequency
    parameter int FAST_CYC = 5000  // period of highest frequency
) (
    input wire logic clk,  // core clock
    input wire logic nrst,  // sync reset, active low
    input wire logic demand,  // demand pulse train
    input wire logic [9:0] hi_pm,  // duty high threshold, per mille
    input wire logic [9:0] lo_pm,  // duty low threshold, per mille
    output logic freq_bad,  // connected signal out of frequency window
    output logic duty_hi,  // duty above high threshold
    output logic duty_lo  // duty below low threshold
);
    afm_tcnt_t per_cnt;  // cycles since last rising edge
    afm_tcnt_t hi_cnt;  // high cycles in that period
    logic prev;  // last demand level
    wire rise = demand && !prev;
    wire stuck = (per_cnt >= SLOW_CYC[`AFM_TW-1:0]);  // no edge for a full slow period
    wire fast = (per_cnt < FAST_CYC[`AFM_TW-1:0]);
    wire [35:0] hi_scaled = hi_cnt * `AFM_PM_FULL;
    wire [35:0] hi_lim = per_cnt * hi_pm;
    wire [35:0] lo_lim = per_cnt * lo_pm;

    // measure each period; a flat line counts as disconnected, not off-frequency
    always_ff @(posedge clk) begin
        if (!nrst) begin
            prev <= 1'b0;
            per_cnt <= '0;
            hi_cnt <= '0;
            freq_bad <= 1'b0;
            duty_hi <= 1'b0;
            duty_lo <= 1'b0;
        end else begin
            prev <= demand;
            if (rise) begin
                per_cnt <= `AFM_TW'(1);
                hi_cnt <= `AFM_TW'(1);
                freq_bad <= fast || stuck;
                duty_hi <= hi_scaled > hi_lim;
                duty_lo <= hi_scaled < lo_lim;
            end else if (stuck) begin
                freq_bad <= 1'b0;  // nothing connected
                duty_hi <= demand;
                duty_lo <= !demand;
            end else begin
                per_cnt <= per_cnt + 1'b1;
                hi_cnt <= hi_cnt + {{(`AFM_TW-1){1'b0}}, demand};
            end
        end
    end

    property p_fast;
        @(posedge clk) disable iff (!nrst) (rise && fast) |=> freq_bad;
    endproperty
    a_fast: assert property (p_fast) else $error("fast demand not flagged");
endmodule : afm_pwm_mon

// ### afm_svc_tool.sv
// service tool model: turns bench command requests into one-cycle command pulses
module afm_svc_tool import afm_pkg::*; (
    input wire logic go,  // issue the command this cycle
    input wire logic [1:0] cmd,  // 1 reset faults, 2 clear log, 3 restore log
    input wire afm_fvec_t image,  // saved log image
    output logic reset_faults,  // reset active faults pulse
    output logic clear_log,  // clear logged faults pulse
    output logic log_load,  // restore log pulse
    output afm_fvec_t log_data  // image offered with a restore
);
    timeunit 1ns;
    timeprecision 1ps;
    // gated by go, so each command lasts exactly the cycle the bench holds it
    assign reset_faults = go && (cmd == 2'h1);
    assign clear_log = go && (cmd == 2'h2);
    assign log_load = go && (cmd == 2'h3);
    // outside a restore the data lines show the inverse, never a stale copy
    assign log_data = log_load ? image : ~image;
endmodule : afm_svc_tool

// ### afm_timeout.sv
// activity watchdog: expires when no activity for limit cycles
module afm_timeout import afm_pkg::*; (
    input wire logic clk,  // core clock
    input wire logic nrst,  // sync reset, active low
    input wire logic act,  // activity seen this cycle
    input wire afm_tcnt_t limit,  // cycles allowed without activity
    output logic expired  // silent for limit cycles
);
    afm_tcnt_t cnt;  // cycles since last activity
    wire at_limit = (cnt >= limit);  // saturates here

    // restart on activity, hold at the limit otherwise
    always_ff @(posedge clk) begin
        if (!nrst) begin
            cnt <= '0;
            expired <= 1'b0;
        end else begin
            cnt <= act ? '0 : (at_limit ? cnt : cnt + 1'b1);
            expired <= !act && at_limit;
        end
    end

    property p_act_clears;
        @(posedge clk) disable iff (!nrst) act |=> !expired;
    endproperty
    a_act_clears: assert property (p_act_clears) else $error("expired after activity");
endmodule : afm_timeout
